/* File: pkg/ugi_pkg.sv */
// constants, register map and types for the interrupt-source block
package ugi_pkg;
  // clock and timing
  localparam int CLK_FREQ_MHZ        = 40;
  localparam int TIMER_PERIOD_US     = 128;
  localparam int TIMER_PERIOD_CYCLES = TIMER_PERIOD_US * CLK_FREQ_MHZ;
  localparam int TIMER_CNT_W         = 13;
  localparam int BUS_COND_US         = 256;
  localparam int BUS_COND_TICKS      = BUS_COND_US / TIMER_PERIOD_US;
  localparam int TICK_CNT_W          = 2;

  // widths
  localparam int PORT_W     = 8;
  localparam int GPIO_W     = 2 * PORT_W;
  localparam int SYNC_W     = GPIO_W + 3;
  localparam int ADR_W      = 8;
  localparam int DAT_W      = 32;
  localparam int USB_ADDR_W = 7;
  localparam int NUM_EP     = 3;
  localparam int NUM_VEC    = 6;
  localparam int VEC_IDX_W  = 3;

  // register indices; byte address is four times the index
  localparam logic [ADR_W-1:0] IDX_PORT0_EN  = 8'h04;
  localparam logic [ADR_W-1:0] IDX_PORT1_EN  = 8'h05;
  localparam logic [ADR_W-1:0] IDX_PORT0_POL = 8'h06;
  localparam logic [ADR_W-1:0] IDX_PORT1_POL = 8'h07;
  localparam logic [ADR_W-1:0] IDX_EP_EN     = 8'h21;
  localparam logic [ADR_W-1:0] IDX_CTRL      = 8'h30;
  localparam logic [ADR_W-1:0] IDX_PENDING   = 8'h31;
  localparam logic [ADR_W-1:0] IDX_USB_ADDR  = 8'h32;

  // reset values
  localparam logic [PORT_W-1:0]     RST_PORT     = 8'h00;
  localparam logic [NUM_EP-1:0]     RST_EP_EN    = 3'h0;
  localparam logic [USB_ADDR_W-1:0] RST_USB_ADDR = 7'h00;

  // control register bit positions
  localparam int CTRL_BUSRST_EN = 0;
  localparam int CTRL_TIMER_EN  = 1;
  localparam int CTRL_GPIO_EN   = 2;
  localparam int CTRL_PS2_MODE  = 3;
  localparam int CTRL_W         = 4;

  // vector / pending bit positions, highest priority first
  localparam int VEC_BUSRST = 0;
  localparam int VEC_TIMER  = 1;
  localparam int VEC_EP0    = 2;
  localparam int VEC_GPIO   = 5;

  // synchroniser lane layout
  localparam int LANE_DP  = GPIO_W;
  localparam int LANE_DM  = GPIO_W + 1;
  localparam int LANE_PS2 = GPIO_W + 2;

  typedef enum logic [1:0] {
    UGI_BR_IDLE,
    UGI_BR_COUNT,
    UGI_BR_DETECT
  } ugi_busrst_e;
endpackage

/* File: pkg/ugi_pin_if.sv */
// carrier between the pin synchroniser and the interrupt logic
`timescale 1ns/1ps
interface ugi_pin_if;
  import ugi_pkg::*;
  logic [SYNC_W-1:0] rawPins;  // asynchronous pin levels
  logic [SYNC_W-1:0] syncPins; // pins after two flops
  modport sync (input rawPins, output syncPins);
  modport core (output rawPins, input syncPins);
endinterface

/* File: verilog/ugi_pin_sync.sv */
// two-flop synchroniser for all asynchronous pins
`timescale 1ns/1ps
module ugi_pin_sync
  import ugi_pkg::*;
(
  input  wire logic clk,    // system clock
  input  wire logic resetn, // async reset, active low
  input  wire logic ce,     // clock enable
  ugi_pin_if.sync   pins    // raw in, synchronised out
);
  logic [SYNC_W-1:0] stage1;

  // first stage feeds only the second stage to contain metastability
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      stage1        <= '0;
      pins.syncPins <= '0;
    end else if (ce) begin
      stage1        <= pins.rawPins;
      pins.syncPins <= stage1;
    end
  end
endmodule

/* File: verilog/ugi_irq_top.sv */
// interrupt sources: timer, bus reset / ps2, endpoints and gpio
`timescale 1ns/1ps
// Summary of operation
// [R1] periodic timer event every 128 us, requested on the vector only while its enable is set
// [R2] firmware should disable timer interrupts before suspend
// [R3] mode bit selects usb bus reset or ps2 activity detection
// [R4] condition qualifies after 128 to 256 us of persistence
// [R5] usb mode: se0 on both lines, event when se0 ends
// [R6] ps2 mode: long low on serial data, event at detection
// [R7] usb device address held at zero during the event
// [R8] event may lag the removed condition by up to 128 us
// [R9] bulk endpoints flag data writes, bad crc too in ack-out modes
// [R10] bulk endpoints flag nak/stall sent and acked in transfers
// [R11] firmware must verify data validity in ack-out modes
// [R12] control endpoint flags mode set to accept setup
// [R13] control endpoint flags zero-length status packet sent
// [R14] control endpoint flags data writes and nak/stall replies
// [R15] endpoint enable register: bits 2..0, reset zero, rest reserved
// [R16] write-only per-pin gpio enables for both ports, reset zero
// [R17] write-only per-pin polarity, 1 rising 0 falling, reset zero
// [R18] gpio vector needs global gpio enable; one shared vector
// [R19] triggered pin blocks others until inactive or disabled
// [R20] sources latch pending, shown while enabled, cleared on ack
// [R21] gpio edges found by comparing synced pin with previous sample
module ugi_irq_top
  import ugi_pkg::*;
#(
  parameter int TICK_CYCLES = TIMER_PERIOD_CYCLES // shorten in simulation
)(
  input  wire logic                  clk,          // system clock
  input  wire logic                  resetn,       // async reset, low
  input  wire logic                  ce,           // clock enable
  input  wire logic                  wb_cyc_i,     // wishbone cycle
  input  wire logic                  wb_stb_i,     // wishbone strobe
  input  wire logic                  wb_we_i,      // wishbone write
  input  wire logic [ADR_W-1:0]      wb_adr_i,     // byte address
  input  wire logic [3:0]            wb_sel_i,     // byte selects
  input  wire logic [DAT_W-1:0]      wb_dat_i,     // write data
  output logic      [DAT_W-1:0]      wb_dat_o,     // read data
  output logic                       wb_ack_o,     // acknowledge
  input  wire logic [PORT_W-1:0]     portZero,     // port_zero pins
  input  wire logic [PORT_W-1:0]     portOne,      // port_one pins
  input  wire logic                  usbDp,        // usb d+ pin
  input  wire logic                  usbDm,        // usb d- pin
  input  wire logic                  ps2SerialDataPin, // ps2 data pin
  input  wire logic [NUM_EP-1:0]     epDataWrite,  // valid data written
  input  wire logic [NUM_EP-1:0]     epBadCrcAckOut, // bad crc, ack-out
  input  wire logic [NUM_EP-1:0]     epNakStall,   // nak/stall sent
  input  wire logic [NUM_EP-2:0]     epInAcked,    // bulk in acked
  input  wire logic                  ctrlSetupMode, // setup accept set
  input  wire logic                  ctrlZeroLenSent, // status zlp sent
  input  wire logic                  irqAck,       // core ack pulse
  input  wire logic [VEC_IDX_W-1:0]  irqAckIndex,  // acked vector
  output logic      [NUM_VEC-1:0]    irqVector,    // requests to core
  output logic      [USB_ADDR_W-1:0] usbAddress    // device address
);
  ////////////////////////////////////////////////////////////////////////
  // helpers

  // byte address of a register index
  function automatic logic [ADR_W-1:0] regAddr(input logic [ADR_W-1:0] i);
    regAddr = ADR_W'({i, 2'b00});
  endfunction

  // one bit set at a vector index
  function automatic logic [NUM_VEC-1:0] vecBit(
    input logic [VEC_IDX_W-1:0] i);
    vecBit = NUM_VEC'(1) << i;
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // pin synchronisation

  ugi_pin_if pinBus();
  logic [GPIO_W-1:0] gpioNow;
  logic              dpNow;
  logic              dmNow;
  logic              ps2Now;

  assign pinBus.rawPins = {ps2SerialDataPin, usbDm, usbDp, portOne,
                           portZero};

  ugi_pin_sync pinSync (
    .clk    (clk),
    .resetn (resetn),
    .ce     (ce),
    .pins   (pinBus.sync)
  );

  assign gpioNow = pinBus.syncPins[GPIO_W-1:0];
  assign dpNow   = pinBus.syncPins[LANE_DP];
  assign dmNow   = pinBus.syncPins[LANE_DM];
  assign ps2Now  = pinBus.syncPins[LANE_PS2];

  ////////////////////////////////////////////////////////////////////////
  // registers and wishbone slave

  logic [GPIO_W-1:0]     pinEnable;
  logic [GPIO_W-1:0]     pinPolarity;
  logic [NUM_EP-1:0]     epEnable;
  logic [CTRL_W-1:0]     ctrl;
  logic [NUM_VEC-1:0]    pending;
  logic                  busReq;
  logic                  wrStrobe;
  logic                  selLow;
  logic [NUM_VEC-1:0]    swClear;
  logic [DAT_W-1:0]      next_rdata;
  ugi_busrst_e           brState;

  assign busReq   = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  assign selLow   = wb_sel_i[0];
  assign wrStrobe = busReq & wb_we_i & selLow;

  // ack one cycle after the request; dropped the cycle after
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      wb_ack_o <= 1'b0;
    end else if (ce) begin
      wb_ack_o <= busReq;
    end
  end

  // read mux; write-only and unmapped registers read as zero
  always_comb begin
    next_rdata = '0;
    unique case (wb_adr_i)
      regAddr(IDX_EP_EN):    next_rdata[NUM_EP-1:0] = epEnable; // R15
      regAddr(IDX_CTRL):     next_rdata[CTRL_W-1:0] = ctrl;
      regAddr(IDX_PENDING):  next_rdata[NUM_VEC-1:0] = pending;
      regAddr(IDX_USB_ADDR): next_rdata[USB_ADDR_W-1:0] = usbAddress;
      default:               next_rdata = '0;
    endcase
  end

  // read data registered with the ack
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      wb_dat_o <= '0;
    end else if (ce && busReq) begin
      wb_dat_o <= wb_we_i ? '0 : next_rdata;
    end
  end

  // gpio enable and polarity, write-only
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      pinEnable   <= {RST_PORT, RST_PORT}; // R16
      pinPolarity <= {RST_PORT, RST_PORT}; // R17
    end else if (ce && wrStrobe) begin
      if (wb_adr_i == regAddr(IDX_PORT0_EN)) begin
        pinEnable[PORT_W-1:0] <= wb_dat_i[PORT_W-1:0]; // R16
      end
      if (wb_adr_i == regAddr(IDX_PORT1_EN)) begin
        pinEnable[GPIO_W-1:PORT_W] <= wb_dat_i[PORT_W-1:0]; // R16
      end
      if (wb_adr_i == regAddr(IDX_PORT0_POL)) begin
        pinPolarity[PORT_W-1:0] <= wb_dat_i[PORT_W-1:0]; // R17
      end
      if (wb_adr_i == regAddr(IDX_PORT1_POL)) begin
        pinPolarity[GPIO_W-1:PORT_W] <= wb_dat_i[PORT_W-1:0]; // R17
      end
    end
  end

  // endpoint enables and control bits
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      epEnable <= RST_EP_EN; // R15
      ctrl     <= '0;
    end else if (ce && wrStrobe) begin
      if (wb_adr_i == regAddr(IDX_EP_EN)) begin
        epEnable <= wb_dat_i[NUM_EP-1:0]; // R15
      end
      if (wb_adr_i == regAddr(IDX_CTRL)) begin
        ctrl <= wb_dat_i[CTRL_W-1:0]; // R3
      end
    end
  end

  // usb address is forced to zero for the whole detected interval
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      usbAddress <= RST_USB_ADDR;
    end else if (ce) begin
      if (brState == UGI_BR_DETECT) begin
        usbAddress <= RST_USB_ADDR; // R7
      end else if (wrStrobe && wb_adr_i == regAddr(IDX_USB_ADDR)) begin
        usbAddress <= wb_dat_i[USB_ADDR_W-1:0];
      end
    end
  end

  // write-one-to-clear on the pending register
  assign swClear = (wrStrobe && wb_adr_i == regAddr(IDX_PENDING)) ?
                   wb_dat_i[NUM_VEC-1:0] : '0;

  ////////////////////////////////////////////////////////////////////////
  // free-running 128 us tick

  logic [TIMER_CNT_W-1:0] timerCnt;
  logic                   tick;

  // the tick also paces the bus condition filter, so it never stops
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      timerCnt <= '0;
      tick     <= 1'b0;
    end else if (ce) begin
      if (timerCnt == TIMER_CNT_W'(TICK_CYCLES - 1)) begin
        timerCnt <= '0;
        tick     <= 1'b1; // R1
      end else begin
        timerCnt <= timerCnt + TIMER_CNT_W'(1);
        tick     <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // bus reset / ps2 activity detector

  logic                  brCond;
  logic [TICK_CNT_W-1:0] brTicks;
  logic                  brEvent;

  // usb mode watches se0, ps2 mode a low data line
  assign brCond = ctrl[CTRL_PS2_MODE] ? ~ps2Now : ~(dpNow | dmNow); // R3 R5 R6

  // the first tick may come at once, so qualification lands between
  // 128 and 256 us; the usb event needs no tick and follows the end of se0 at once
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      brState <= UGI_BR_IDLE;
      brTicks <= '0;
      brEvent <= 1'b0;
    end else if (ce) begin
      brEvent <= 1'b0;
      unique case (brState)
        UGI_BR_IDLE: begin
          brTicks <= '0;
          if (brCond) begin
            brState <= UGI_BR_COUNT;
          end
        end
        UGI_BR_COUNT: begin
          if (!brCond) begin
            brState <= UGI_BR_IDLE;
          end else if (tick) begin
            if (brTicks == TICK_CNT_W'(BUS_COND_TICKS - 1)) begin // R4
              brState <= UGI_BR_DETECT;
              brEvent <= ctrl[CTRL_PS2_MODE]; // R6
            end else begin
              brTicks <= brTicks + TICK_CNT_W'(1);
            end
          end
        end
        UGI_BR_DETECT: begin
          if (!brCond) begin
            brState <= UGI_BR_IDLE;
            brEvent <= ~ctrl[CTRL_PS2_MODE]; // R5 R8
          end
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // endpoint events

  logic [NUM_EP-1:0] epEvent;

  // bad-crc writes in ack-out modes count; firmware checks the data
  always_comb begin
    epEvent = epDataWrite | epBadCrcAckOut | epNakStall; // R9 R14
    epEvent[0] = epEvent[0] | ctrlSetupMode | ctrlZeroLenSent; // R12 R13
    epEvent[NUM_EP-1:1] = epEvent[NUM_EP-1:1] | epInAcked; // R10
  end

  ////////////////////////////////////////////////////////////////////////
  // gpio edge detection with single-pin lockout

  logic [GPIO_W-1:0] gpioPrev;
  logic [GPIO_W-1:0] gpioLock;
  logic [GPIO_W-1:0] edgeHit;
  logic [GPIO_W-1:0] lockRelease;
  logic [GPIO_W-1:0] next_lock;
  logic              gpioEvent;

  // rising when polarity is one, falling when zero
  assign edgeHit = pinEnable & ((gpioNow & ~gpioPrev & pinPolarity) |
                   (~gpioNow & gpioPrev & ~pinPolarity)); // R21 R17 R16
  // lock drops once its pin is back at the non-trigger level
  assign lockRelease = (gpioNow ^ pinPolarity) | ~pinEnable; // R19

  // fixed pin priority: the lowest set edge takes the lock
  always_comb begin
    next_lock = gpioLock & ~lockRelease;
    gpioEvent = 1'b0;
    if (next_lock == '0 && edgeHit != '0) begin
      next_lock = edgeHit & (~edgeHit + GPIO_W'(1)); // R19
      gpioEvent = 1'b1;
    end
  end

  // previous sample and lock state
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      gpioPrev <= '0;
      gpioLock <= '0;
    end else if (ce) begin
      gpioPrev <= gpioNow; // R21
      gpioLock <= next_lock; // R19
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // pending requests and vector outputs

  logic [NUM_VEC-1:0] newEvents;
  logic [NUM_VEC-1:0] ackClear;
  logic [NUM_VEC-1:0] vecEnable;

  assign newEvents = {gpioEvent, epEvent, tick, brEvent};
  assign ackClear  = irqAck ? vecBit(irqAckIndex) : '0;
  assign vecEnable = {ctrl[CTRL_GPIO_EN], epEnable, ctrl[CTRL_TIMER_EN],
                      ctrl[CTRL_BUSRST_EN]}; // R18 R1

  // a new event in the clearing cycle wins over the clear
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      pending <= '0;
    end else if (ce) begin
      pending <= (pending & ~ackClear & ~swClear) | newEvents; // R20
    end
  end

  // presented only while enabled; the timer keeps ticking and latching pending when disabled
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      irqVector <= '0;
    end else if (ce) begin
      irqVector <= pending & vecEnable; // R20 R1 R18
    end
  end
endmodule

/* File: sim/ugi_irq_top_chk.sv */
// port assertions for the interrupt-source block
`timescale 1ns/1ps
module ugi_irq_top_chk
  import ugi_pkg::*;
#(
  parameter int TICK_CYCLES = TIMER_PERIOD_CYCLES // timer period
)(
  input wire logic                  clk,             // clock
  input wire logic                  resetn,          // reset
  input wire logic                  wb_cyc_i,        // cycle
  input wire logic                  wb_stb_i,        // strobe
  input wire logic [DAT_W-1:0]      wb_dat_o,        // read data
  input wire logic                  wb_ack_o,        // ack
  input wire logic [PORT_W-1:0]     portZero,        // pins
  input wire logic [PORT_W-1:0]     portOne,         // pins
  input wire logic [NUM_EP-1:0]     epDataWrite,     // events
  input wire logic [NUM_EP-1:0]     epBadCrcAckOut,  // events
  input wire logic [NUM_EP-1:0]     epNakStall,      // events
  input wire logic [NUM_EP-2:0]     epInAcked,       // events
  input wire logic                  ctrlSetupMode,   // event
  input wire logic                  ctrlZeroLenSent, // event
  input wire logic                  ps2SerialDataPin, // ps2 data
  input wire logic                  irqAck,          // core ack
  input wire logic [VEC_IDX_W-1:0]  irqAckIndex,     // acked vector
  input wire logic [NUM_VEC-1:0]    irqVector,       // requests
  input wire logic [USB_ADDR_W-1:0] usbAddress       // address
);
  logic [7:0]        chgHist;
  logic [PORT_W-1:0] lastZ;
  logic [PORT_W-1:0] lastO;
  int                tcnt;
  logic              ev0;
  logic              ev1;
  ////////////////////////////////////////////////////////////////////////////
  // any event of the control endpoint and of the first bulk endpoint
  assign ev0 = ctrlSetupMode | ctrlZeroLenSent | epDataWrite[0]
             | epBadCrcAckOut[0] | epNakStall[0];
  assign ev1 = epDataWrite[1] | epBadCrcAckOut[1] | epNakStall[1]
             | epInAcked[0];
  // pin history spans the synchroniser and edge-detect delay
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      chgHist <= '0;
      lastZ   <= '0;
      lastO   <= '0;
      tcnt    <= 0;
    end else begin
      lastZ   <= portZero;
      lastO   <= portOne;
      chgHist <= {chgHist[6:0], (portZero != lastZ) || (portOne != lastO)};
      tcnt    <= (tcnt == TICK_CYCLES - 1) ? 0 : tcnt + 1;
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  default clocking @(posedge clk); endclocking
  default disable iff (!resetn);
  ack_latency_a: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=>
    wb_ack_o) else $error("ack late");
  ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack too long");
  read_hold_a: assert property (!(wb_cyc_i && wb_stb_i && !wb_ack_o)
    |=> $stable(wb_dat_o)) else $error("read data moved");
  ack_clear_a: assert property (irqAck && irqAckIndex == 3'h3 && !ev1
    |-> ##2 !irqVector[3]) else $error("request not cleared");
  ep1_cause_a: assert property ($rose(irqVector[3])
    |-> $past(ev1, 2) || $past(wb_ack_o)) else $error("ep1 no cause");
  ep0_cause_a: assert property ($rose(irqVector[VEC_EP0])
    |-> $past(ev0, 2) || $past(wb_ack_o)) else $error("ep0 no cause");
  gpio_cause_a: assert property ($rose(irqVector[VEC_GPIO])
    |-> (|chgHist) || $past(wb_ack_o)) else $error("gpio no edge");
  timer_phase_a: assert property ($rose(irqVector[VEC_TIMER])
    |-> tcnt <= 3 || $past(wb_ack_o)) else $error("timer off phase");
  addr_zero_a: assert property ($rose(irqVector[VEC_BUSRST])
    |-> usbAddress == '0) else $error("addr kept");
  cover property ($fell(ps2SerialDataPin) ##[1:60]
    $rose(irqVector[VEC_BUSRST]));
  cover property ($rose(irqVector[VEC_BUSRST]));
  cover property ($rose(irqVector[VEC_GPIO]));
  cover property (irqAck && irqAckIndex == 3'h3);
endmodule
bind ugi_irq_top ugi_irq_top_chk #(.TICK_CYCLES(TICK_CYCLES)) chk (
  .clk, .resetn, .wb_cyc_i, .wb_stb_i, .wb_dat_o, .wb_ack_o, .portZero,
  .portOne, .epDataWrite, .epBadCrcAckOut, .epNakStall, .epInAcked,
  .ctrlSetupMode, .ctrlZeroLenSent, .ps2SerialDataPin, .irqAck,
  .irqAckIndex, .irqVector, .usbAddress);

/* File: sim/ugi_core_model.sv */
// processor-core model acknowledging the highest-priority request
`timescale 1ns/1ps
module ugi_core_model
  import ugi_pkg::*;
(
  input  wire logic                 clk,        // system clock
  input  wire logic                 resetn,     // async reset, low
  input  wire logic [NUM_VEC-1:0]   irqVector,  // requests
  input  wire logic                 coreEn,     // interrupts accepted
  input  wire logic [3:0]           coreDelay,  // vectoring delay
  output logic                      irqAck,     // ack pulse
  output logic      [VEC_IDX_W-1:0] irqAckIndex // acked vector
);
  logic [3:0] cnt;
  logic [2:0] hold;
  // lowest set bit wins, as vector 0 has top priority
  function automatic logic [VEC_IDX_W-1:0] first(logic [NUM_VEC-1:0] v);
    first = '0;
    for (int i = NUM_VEC - 1; i >= 0; i--)
      if (v[i]) first = VEC_IDX_W'(i);
  endfunction
  // hold waits out the two edges a request needs to fall after an ack
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      {irqAck, irqAckIndex, cnt, hold} <= '0;
    end else begin
      irqAck      <= 1'b0;
      irqAckIndex <= ~irqAckIndex; // meaningless without the ack
      if (irqAck) hold <= 3'h4;
      else if (hold != 3'h0) hold <= hold - 3'h1;
      else if (coreEn && |irqVector) begin
        cnt <= cnt + 4'h1;
        if (cnt >= coreDelay) begin
          cnt         <= '0;
          irqAck      <= 1'b1;
          irqAckIndex <= first(irqVector);
        end
      end
    end
  end
endmodule

/* File: sim/tb_top.sv */
// self-checking bench for the interrupt-source block
`timescale 1ns/1ps
`define CHK(n, e, g) begin checks++; if ((g) !== (e)) begin errors++; \
  $display("BAD %s expected %h seen %h", n, e, g); end end
module tb_top
  import ugi_pkg::*;
;
  localparam int TICK = 16;
  localparam logic [31:0] PM = 32'hffff_fffd; // timer bit keeps latching
  localparam logic [7:0] RL [8] = '{IDX_PORT0_EN, IDX_PORT1_EN,
    IDX_PORT0_POL, IDX_PORT1_POL, IDX_EP_EN, IDX_CTRL, IDX_USB_ADDR, 8'h3f};
  logic        clk, resetn, ce, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o;
  logic [7:0]  wb_adr_i, portZero, portOne;
  logic [3:0]  wb_sel_i, coreDelay;
  logic [31:0] wb_dat_i, wb_dat_o, seed, expQ[$], mskQ[$];
  logic        usbDp, usbDm, ps2SerialDataPin, ctrlSetupMode;
  logic        ctrlZeroLenSent, irqAck, coreEn;
  logic [2:0]  epDataWrite, epBadCrcAckOut, epNakStall, irqAckIndex;
  logic [1:0]  epInAcked;
  logic [5:0]  irqVector;
  logic [6:0]  usbAddress;
  logic [12:0] evBus;
  logic [31:0] expV, gotV;
  int          errors = 0;
  int          checks = 0;
  int          k;
  assign {epInAcked, epNakStall, epBadCrcAckOut, epDataWrite,
          ctrlZeroLenSent, ctrlSetupMode} = evBus;
  ugi_irq_top #(.TICK_CYCLES(TICK)) DUT (.clk, .resetn, .ce, .wb_cyc_i,
    .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o,
    .wb_ack_o, .portZero, .portOne, .usbDp, .usbDm, .ps2SerialDataPin,
    .epDataWrite, .epBadCrcAckOut, .epNakStall, .epInAcked, .ctrlSetupMode,
    .ctrlZeroLenSent, .irqAck, .irqAckIndex, .irqVector, .usbAddress);
  ugi_core_model core (.clk, .resetn, .irqVector, .coreEn, .coreDelay,
    .irqAck, .irqAckIndex);
  ////////////////////////////////////////////////////////////////////////////
  function automatic logic [31:0] lfsr(logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  task automatic waitCyc(int n);
    repeat (n) @(posedge clk);
  endtask
  // classic cycle: request held until ack is sampled, then released
  task automatic wbXfer(logic [7:0] idx, logic we, logic [31:0] d);
    @(posedge clk);
    {wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_dat_i} <= {2'b11, we,
      idx << 2, d};
    do @(posedge clk); while (wb_ack_o !== 1'b1);
    {wb_cyc_i, wb_stb_i} <= 2'b00;
  endtask
  task automatic wbRead(logic [7:0] idx, logic [31:0] e, logic [31:0] m = '1);
    expQ.push_back(e);
    mskQ.push_back(m);
    wbXfer(idx, 1'b0, '0);
  endtask
  task automatic pulse(logic [12:0] m);
    @(posedge clk);
    evBus <= m;
    @(posedge clk);
    evBus <= '0;
  endtask
  task automatic complete_run;
    $display("checks %0d errors %0d", checks, errors);
    if (errors == 0 && checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  // read results are matched against the oldest note
  // pop once into locals: the macro reads its arguments more than once
  always @(posedge clk) begin
    if (wb_ack_o === 1'b1 && wb_we_i === 1'b0 && expQ.size() > 0) begin
      expV = expQ.pop_front();
      gotV = wb_dat_o & mskQ.pop_front();
      `CHK("rdata", expV, gotV)
    end
  end
  initial begin
    waitCyc(20000);
    errors++;
    complete_run();
  end
  initial begin
    {wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_dat_i, evBus} = '0;
    {wb_sel_i, ce, portZero, portOne} = {4'h1, 1'b1, 8'h02, 8'h01};
    {usbDp, usbDm, ps2SerialDataPin, coreEn, coreDelay} = 8'ha0;
    seed = 32'h29b5;
    resetn = 1'b0;
    waitCyc(2);
    resetn <= 1'b1;
    for (int i = 0; i < 8; i++) wbRead(RL[i], '0);
    wbRead(IDX_PENDING, '0, PM);
    wbWrite(IDX_EP_EN, 32'hff);
    wbRead(IDX_EP_EN, 32'h7);
    for (int j = 0; j < 13; j++) begin
      k = j < 2 ? 2 : (j < 11 ? 2 + (j - 2) % 3 : 3 + j - 11);
      pulse(13'h1 << j);
      waitCyc(3);
      `CHK("epvec", 6'h1 << k, irqVector)
      wbWrite(IDX_PENDING, 32'h3f);
      waitCyc(2);
    end
    wbWrite(IDX_EP_EN, 32'h3);
    pulse(13'h10);
    waitCyc(3);
    `CHK("masked", 6'h00, irqVector)
    wbRead(IDX_PENDING, 32'h10, PM);
    coreEn <= 1'b1;
    wbWrite(IDX_EP_EN, 32'h7);
    coreDelay <= 4'h5;
    pulse(13'h200);
    waitCyc(20);
    wbRead(IDX_PENDING, '0, PM);
    coreEn <= 1'b0;
    wbWrite(IDX_CTRL, 32'h2);
    waitCyc(TICK + 4);
    `CHK("timer", 1'b1, irqVector[VEC_TIMER])
    coreEn <= 1'b1;
    waitCyc(4 * TICK);
    coreEn <= 1'b0;
    wbWrite(IDX_CTRL, '0);
    wbWrite(IDX_PENDING, 32'h3f);
    waitCyc(3 * TICK);
    `CHK("timeroff", 6'h00, irqVector)
    wbRead(IDX_PENDING, 32'h2);
    for (int i = 0; i < 4; i++) begin
      seed = lfsr(seed);
      wbWrite(IDX_USB_ADDR, seed);
      wbRead(IDX_USB_ADDR, {25'h0, seed[6:0]});
      `CHK("addr", seed[6:0], usbAddress)
    end
    wbWrite(IDX_USB_ADDR, 32'h55);
    wbWrite(IDX_CTRL, 32'h1);
    wbWrite(IDX_PENDING, 32'h3f);
    {usbDp, usbDm} <= 2'b00;
    waitCyc(TICK / 2);
    {usbDp, usbDm} <= 2'b10;
    waitCyc(TICK + 6);
    `CHK("shortse0", 6'h00, irqVector)
    `CHK("addrkept", 7'h55, usbAddress)
    {usbDp, usbDm} <= 2'b00;
    waitCyc(3 * TICK);
    `CHK("se0addr", 7'h00, usbAddress)
    `CHK("se0wait", 6'h00, irqVector)
    {usbDp, usbDm} <= 2'b10;
    waitCyc(6);
    `CHK("busrst", 6'h01, irqVector)
    wbWrite(IDX_PENDING, 32'h3f);
    wbWrite(IDX_CTRL, 32'h9);
    ps2SerialDataPin <= 1'b0;
    waitCyc(2 * TICK + 8);
    `CHK("ps2", 6'h01, irqVector)
    ps2SerialDataPin <= 1'b1;
    wbWrite(IDX_CTRL, 32'h4);
    wbWrite(IDX_PORT0_EN, 32'h3);
    wbWrite(IDX_PORT0_POL, 32'h1);
    wbWrite(IDX_PENDING, 32'h3f);
    portZero <= 8'h03;
    waitCyc(6);
    `CHK("rise", 6'h20, irqVector)
    wbWrite(IDX_PENDING, 32'h3f);
    portZero <= 8'h01;
    waitCyc(6);
    `CHK("locked", 6'h00, irqVector)
    portZero <= 8'h00;
    waitCyc(4);
    portZero <= 8'h02;
    waitCyc(4);
    portZero <= 8'h00;
    waitCyc(6);
    `CHK("fall", 6'h20, irqVector)
    wbWrite(IDX_PENDING, 32'h3f);
    wbWrite(IDX_CTRL, '0);
    wbWrite(IDX_PORT1_EN, 32'hff);
    portZero <= 8'h02;
    waitCyc(4);
    portOne <= 8'h00;
    waitCyc(6);
    `CHK("noglobal", 6'h00, irqVector)
    wbRead(IDX_PENDING, 32'h20, PM);
    complete_run();
  end
  task automatic wbWrite(logic [7:0] idx, logic [31:0] d);
    wbXfer(idx, 1'b1, d);
  endtask
endmodule
